// File: core/ims_pkg.sv
// constants, commands and states of the two-wire master sequencer
package ims_pkg;

  // widths
  localparam int BAUD_W = 8;  // reload value width
  localparam int BYTE_W = 8;  // data byte width
  localparam int BITCNT_W = 4;  // bit counter width
  localparam int PIN_W = 2;  // scl and sda sampled together
  localparam int EV_W = 4;  // event toggles back to clk domain

  // bit positions inside the synchronised vectors
  localparam int PIN_SCL = 1;
  localparam int PIN_SDA = 0;
  localparam int EV_DONE = 3;
  localparam int EV_START = 2;
  localparam int EV_STOP = 1;
  localparam int EV_BFCLR = 0;

  // bit counter marks
  localparam logic [3:0] BIT_EIGHTH = 4'h7;  // index of the eighth clock
  localparam logic [3:0] BIT_NINTH = 4'h8;  // index of the ninth clock

  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] BITCNT_RST = 4'h0;

  // commands handed from the software side to the link side
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_START = 3'h1,
    CMD_RESTART = 3'h2,
    CMD_TX = 3'h3,
    CMD_RX = 3'h4,
    CMD_ACK = 3'h5,
    CMD_STOP = 3'h6
  } ims_cmd_t;

  // link-side sequencer states, gray coded along the usual path
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_START1 = 4'h1,
    S_START2 = 4'h3,
    S_RS_LOW = 4'h2,
    S_RS_SDA = 4'h6,
    S_RS_WAITHI = 4'h7,
    S_RS_HI = 4'h5,
    S_RS_LOWSDA = 4'h4,
    S_BIT_LOW = 4'hc,
    S_BIT_HIGH = 4'hd,
    S_STOP1 = 4'hf,
    S_STOP2 = 4'he,
    S_STOP3 = 4'ha
  } ims_state_t;

endpackage : ims_pkg

// File: core/ims_baud_if.sv
// carrier between the sequencer and its baud counter
`timescale 1ns/1ps
interface ims_baud_if #(parameter int W = 8);
  logic load;  // reload the counter now
  logic run;  // count while high
  logic [W-1:0] reload;  // value taken on load and on rollover
  logic tick;  // one-cycle rollover pulse
  modport ctrl(output load, output run, output reload, input tick);
  modport cnt(input load, input run, input reload, output tick);
endinterface : ims_baud_if

// File: core/ims_sync.sv
// two-flop synchroniser for a vector of independent levels or toggles
`timescale 1ns/1ps
module ims_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;  // first stage, read only by q

  // each bit crosses on its own, so only single-bit changes may pass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ims_sync

// File: core/ims_baud.sv
// reloadable down counter that paces every bus phase
`timescale 1ns/1ps
module ims_baud #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  ims_baud_if.cnt bi
);
  logic [W-1:0] cnt;  // current count

  // rollover when the count reaches zero while running
  assign bi.tick = bi.run && !bi.load && (cnt == '0);

  // load wins; rollover reloads so the period is reload plus one cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (bi.load) begin
      cnt <= bi.reload;
    end else if (bi.run) begin
      if (cnt == '0) begin
        cnt <= bi.reload;
      end else begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule : ims_baud

// File: core/ims_master.sv
// two-wire bus master sequencer: software side on clk, bus side on link_clk
//
// Behaviour
// - start request with lines high loads baud
// - lines high at timeout: data low, start-seen
// - one more period, clear start bit, halt
// - line low during start: collision, abort
// - restart pulls clock low, releases data
// - data high: release clock, then start
// - restart done clears bit, no reload
// - start-seen early, port irq at timeout
// - restart ignored while busy
// - restart collision on data or clock low
// - buffer write sets full, starts shifting
// - data changes after fall, low-high periods
// - eighth fall clears full, releases data
// - ninth clock captures slave acknowledge
// - after ninth, irq, halt, clock low
// - write while busy sets write collision
// - receive request only honoured when idle
// - receive toggles clock, shifts in bits
// - eighth fall: copy byte, full, irq, halt
// - buffer read clears full flag
// - ack sequence clocks chosen value, clears
// - stop drives data low, clock, release
`timescale 1ns/1ps
module ims_master #(
  parameter int BAUD_W = ims_pkg::BAUD_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic start_set,
  input wire logic restart_set,
  input wire logic receive_set,
  input wire logic ack_set,
  input wire logic stop_set,
  input wire logic ack_value_to_send,
  input wire logic [BAUD_W-1:0] baud_reload_value,
  input wire logic buf_wr,
  input wire logic [7:0] buf_wdata,
  input wire logic buf_rd,
  input wire logic port_irq_clr,
  input wire logic collision_irq_clr,
  input wire logic write_collision_clr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic start_request_bit,
  output logic restart_request_bit,
  output logic receive_request_bit,
  output logic ack_sequence_request,
  output logic stop_request_bit,
  output logic buffer_full_flag,
  output logic write_collision_flag,
  output logic port_irq_flag,
  output logic collision_irq_flag,
  output logic slave_ack_result,
  output logic start_seen,
  output logic stop_seen,
  output logic [7:0] transfer_buffer,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n
);

  // a reload narrower than two bits cannot cover the pin sync delay
  if (BAUD_W < 2) begin : g_bad_width
    $error("ims_master: BAUD_W must be at least 2");
  end

  // set wins over clear for every sticky bit
  function automatic logic sticky(logic cur, logic set_it, logic clr_it);
    return set_it | (cur & ~clr_it);
  endfunction : sticky

  // ---------------- software side, clk domain ----------------
  ims_pkg::ims_cmd_t cmd;  // command in flight
  ims_pkg::ims_cmd_t next_cmd;  // command chosen this cycle
  logic [7:0] cmd_data;  // byte held for the link side
  logic cmd_ackv;  // acknowledge value held for the link side
  logic [BAUD_W-1:0] cmd_reload;  // reload held for the link side
  logic req_tgl;  // flips once per issued command
  logic busy;  // a command is outstanding
  logic issue;  // a command leaves this cycle
  logic write_collision_flag_set;  // a buffer write was refused
  logic [ims_pkg::EV_W-1:0] ev_q;  // synchronised link toggles
  logic [ims_pkg::EV_W-1:0] ev_prev;  // last seen toggles
  logic [ims_pkg::EV_W-1:0] ev_hit;  // one-cycle event pulses
  logic done;  // link finished the command
  logic ok_done;  // finished without collision

  // link-side results, stable whenever the done toggle is seen
  logic res_coll;
  logic res_ack;
  logic [7:0] res_rx;
  logic done_tgl;
  logic evs_tgl;
  logic evp_tgl;
  logic evb_tgl;

  assign ev_hit = ev_q ^ ev_prev;
  assign done = ev_hit[ims_pkg::EV_DONE];
  assign ok_done = done && !res_coll;
  assign issue = (next_cmd != ims_pkg::CMD_NONE);

  // no queueing: while busy every request is dropped
  always_comb begin
    next_cmd = ims_pkg::CMD_NONE;
    if (!busy) begin
      if (start_set) begin
        next_cmd = ims_pkg::CMD_START;
      end else if (restart_set) begin
        next_cmd = ims_pkg::CMD_RESTART;
      end else if (stop_set) begin
        next_cmd = ims_pkg::CMD_STOP;
      end else if (ack_set) begin
        next_cmd = ims_pkg::CMD_ACK;
      end else if (receive_set) begin
        next_cmd = ims_pkg::CMD_RX;
      end else if (buf_wr) begin
        next_cmd = ims_pkg::CMD_TX;
      end
    end
  end

  // a write that did not become a transmit is a write collision
  assign write_collision_flag_set = buf_wr && (next_cmd != ims_pkg::CMD_TX);

  // link event toggles into this domain
  ims_sync #(.W(ims_pkg::EV_W)) u_ev_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({done_tgl, evs_tgl, evp_tgl, evb_tgl}),
    .q(ev_q)
  );

  // edge memory for the toggles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev <= '0;
    end else begin
      ev_prev <= ev_q;
    end
  end

  // handshake: data held stable while the toggle crosses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= ims_pkg::CMD_NONE;
      cmd_data <= ims_pkg::BYTE_RST;
      cmd_ackv <= 1'b0;
      cmd_reload <= '0;
      req_tgl <= 1'b0;
      busy <= 1'b0;
    end else if (issue) begin
      cmd <= next_cmd;
      cmd_data <= buf_wdata;
      cmd_ackv <= ack_value_to_send;
      cmd_reload <= baud_reload_value;
      req_tgl <= ~req_tgl;
      busy <= 1'b1;
    end else if (done) begin
      busy <= 1'b0;  // issue and done never meet
    end
  end

  // request bits: set on issue, cleared by hardware when the link is done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_request_bit <= 1'b0;
      restart_request_bit <= 1'b0;
      receive_request_bit <= 1'b0;
      ack_sequence_request <= 1'b0;
      stop_request_bit <= 1'b0;
    end else begin
      start_request_bit <= sticky(start_request_bit,
        next_cmd == ims_pkg::CMD_START, done);
      restart_request_bit <= sticky(restart_request_bit,
        next_cmd == ims_pkg::CMD_RESTART, done);
      receive_request_bit <= sticky(receive_request_bit,
        next_cmd == ims_pkg::CMD_RX, done);
      ack_sequence_request <= sticky(ack_sequence_request,
        next_cmd == ims_pkg::CMD_ACK, done);
      stop_request_bit <= sticky(stop_request_bit,
        next_cmd == ims_pkg::CMD_STOP, done);
    end
  end

  // interrupt and collision flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_irq_flag <= 1'b0;
      collision_irq_flag <= 1'b0;
      write_collision_flag <= 1'b0;
    end else begin
      port_irq_flag <= sticky(port_irq_flag, ok_done,
        port_irq_clr);
      collision_irq_flag <= sticky(collision_irq_flag, done && res_coll,
        collision_irq_clr);
      write_collision_flag <= sticky(write_collision_flag, write_collision_flag_set,
        write_collision_clr);
    end
  end

  // buffer, full flag and acknowledge result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_buffer <= ims_pkg::BYTE_RST;
      buffer_full_flag <= 1'b0;
      slave_ack_result <= 1'b0;
    end else begin
      buffer_full_flag <= sticky(buffer_full_flag,
        (next_cmd == ims_pkg::CMD_TX) ||
        (ok_done && cmd == ims_pkg::CMD_RX),
        buf_rd || ev_hit[ims_pkg::EV_BFCLR]);
      if (next_cmd == ims_pkg::CMD_TX) begin
        transfer_buffer <= buf_wdata;  // refused writes never land
      end else if (ok_done && cmd == ims_pkg::CMD_RX) begin
        transfer_buffer <= res_rx;
      end
      if (ok_done && cmd == ims_pkg::CMD_TX) begin
        slave_ack_result <= res_ack;
      end
    end
  end

  // bus condition status: a start hides the last stop and back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else if (ev_hit[ims_pkg::EV_START]) begin
      start_seen <= 1'b1;
      stop_seen <= 1'b0;
    end else if (ev_hit[ims_pkg::EV_STOP]) begin
      start_seen <= 1'b0;
      stop_seen <= 1'b1;
    end
  end

  // ---------------- bus side, link_clk domain ----------------
  ims_pkg::ims_state_t state;  // sequencer state
  ims_pkg::ims_cmd_t lcmd;  // command being run
  logic [ims_pkg::PIN_W-1:0] pin_q;  // synchronised scl and sda
  logic scl_s;  // scl as sampled
  logic sda_s;  // sda as sampled
  logic req_q;  // synchronised request toggle
  logic req_seen;  // last accepted toggle
  logic [7:0] shreg;  // shift_register
  logic [3:0] bitcnt;  // clocks of the current byte
  logic bit_drive;  // next data bit, 1 pulls sda low
  logic scl_low;  // want scl pulled low
  logic sda_low;  // want sda pulled low
  logic ld;  // reload the baud counter
  logic stop_armed;  // stop already reported
  logic [BAUD_W-1:0] lreload;  // reload taken with the command
  logic stretch;  // scl released but still held low outside
  logic abort_now;  // collision seen in this state
  logic tick;  // baud rollover

  ims_baud_if #(.W(BAUD_W)) bif ();

  assign scl_s = pin_q[ims_pkg::PIN_SCL];
  assign sda_s = pin_q[ims_pkg::PIN_SDA];
  assign tick = bif.tick;

  // pins are asynchronous to the link clock
  ims_sync #(.W(ims_pkg::PIN_W)) u_pin_sync (
    .clk(link_clk),
    .rst_n(rst_n),
    .d({scl_in, sda_in}),
    .q(pin_q)
  );

  // request toggle into the link domain
  ims_sync #(.W(1)) u_req_sync (
    .clk(link_clk),
    .rst_n(rst_n),
    .d(req_tgl),
    .q(req_q)
  );

  // clock arbitration: hold the count in reload until scl reads high
  assign stretch = !scl_s && (state == ims_pkg::S_BIT_HIGH ||
    state == ims_pkg::S_RS_WAITHI || state == ims_pkg::S_STOP2);
  assign bif.load = ld || stretch;
  assign bif.run = (state != ims_pkg::S_IDLE);
  assign bif.reload = lreload;

  ims_baud #(.W(BAUD_W)) u_baud (
    .clk(link_clk),
    .rst_n(rst_n),
    .bi(bif)
  );

  // collision checks of the start and restart phases
  always_comb begin
    case (state)
      ims_pkg::S_START1: abort_now = !scl_s || !sda_s;
      ims_pkg::S_RS_SDA: abort_now = tick && !sda_s;
      ims_pkg::S_RS_WAITHI: abort_now = scl_s && !sda_s;
      ims_pkg::S_RS_HI: abort_now = !scl_s || !sda_s;
      default: abort_now = 1'b0;
    endcase
  end

  // sequencer: one command from idle back to idle
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ims_pkg::S_IDLE;
      lcmd <= ims_pkg::CMD_NONE;
      req_seen <= 1'b0;
      shreg <= ims_pkg::BYTE_RST;
      bitcnt <= ims_pkg::BITCNT_RST;
      bit_drive <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      ld <= 1'b0;
      stop_armed <= 1'b0;
      lreload <= '0;
      res_coll <= 1'b0;
      res_ack <= 1'b0;
      res_rx <= ims_pkg::BYTE_RST;
      done_tgl <= 1'b0;
      evs_tgl <= 1'b0;
      evp_tgl <= 1'b0;
      evb_tgl <= 1'b0;
    end else begin
      ld <= 1'b0;
      if (abort_now) begin
        // give the bus back and report the collision
        res_coll <= 1'b1;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
        done_tgl <= ~done_tgl;
        state <= ims_pkg::S_IDLE;
      end else begin
        case (state)
          ims_pkg::S_IDLE: begin
            if (req_q != req_seen) begin
              req_seen <= req_q;
              lcmd <= cmd;
              lreload <= cmd_reload;
              res_coll <= 1'b0;
              bitcnt <= ims_pkg::BITCNT_RST;
              ld <= 1'b1;
              case (cmd)
                ims_pkg::CMD_START: begin
                  if (scl_s && sda_s) begin
                    state <= ims_pkg::S_START1;
                  end else begin
                    res_coll <= 1'b1;
                    done_tgl <= ~done_tgl;
                  end
                end
                ims_pkg::CMD_RESTART: begin
                  scl_low <= 1'b1;
                  state <= ims_pkg::S_RS_LOW;
                end
                ims_pkg::CMD_TX: begin
                  shreg <= cmd_data;
                  bit_drive <= ~cmd_data[7];
                  scl_low <= 1'b1;
                  state <= ims_pkg::S_BIT_LOW;
                end
                ims_pkg::CMD_RX: begin
                  bit_drive <= 1'b0;  // let the slave drive
                  scl_low <= 1'b1;
                  state <= ims_pkg::S_BIT_LOW;
                end
                ims_pkg::CMD_ACK: begin
                  bit_drive <= ~cmd_ackv;
                  bitcnt <= ims_pkg::BIT_NINTH;
                  scl_low <= 1'b1;
                  state <= ims_pkg::S_BIT_LOW;
                end
                ims_pkg::CMD_STOP: begin
                  sda_low <= 1'b1;
                  scl_low <= 1'b1;
                  state <= ims_pkg::S_STOP1;
                end
                default: begin
                  done_tgl <= ~done_tgl;
                end
              endcase
            end
          end
          ims_pkg::S_START1: begin
            if (tick) begin
              sda_low <= 1'b1;
              evs_tgl <= ~evs_tgl;
              ld <= 1'b1;
              state <= ims_pkg::S_START2;
            end
          end
          ims_pkg::S_START2: begin
            if (tick) begin
              done_tgl <= ~done_tgl;
              state <= ims_pkg::S_IDLE;
            end
          end
          ims_pkg::S_RS_LOW: begin
            if (!scl_s) begin
              sda_low <= 1'b0;
              ld <= 1'b1;
              state <= ims_pkg::S_RS_SDA;
            end
          end
          ims_pkg::S_RS_SDA: begin
            if (tick) begin
              scl_low <= 1'b0;
              state <= ims_pkg::S_RS_WAITHI;
            end
          end
          ims_pkg::S_RS_WAITHI: begin
            if (scl_s) begin
              ld <= 1'b1;
              state <= ims_pkg::S_RS_HI;
            end
          end
          ims_pkg::S_RS_HI: begin
            if (tick) begin
              sda_low <= 1'b1;
              evs_tgl <= ~evs_tgl;
              state <= ims_pkg::S_RS_LOWSDA;
            end
          end
          ims_pkg::S_RS_LOWSDA: begin
            if (tick) begin
              scl_low <= 1'b1;
              done_tgl <= ~done_tgl;
              state <= ims_pkg::S_IDLE;
            end
          end
          ims_pkg::S_BIT_LOW: begin
            sda_low <= bit_drive;
            if (tick) begin
              scl_low <= 1'b0;
              state <= ims_pkg::S_BIT_HIGH;
            end
          end
          ims_pkg::S_BIT_HIGH: begin
            if (tick) begin
              scl_low <= 1'b1;
              bitcnt <= bitcnt + 4'h1;
              state <= ims_pkg::S_BIT_LOW;
              case (lcmd)
                ims_pkg::CMD_TX: begin
                  if (bitcnt == ims_pkg::BIT_NINTH) begin
                    res_ack <= sda_s;
                    done_tgl <= ~done_tgl;
                    state <= ims_pkg::S_IDLE;
                  end else if (bitcnt == ims_pkg::BIT_EIGHTH) begin
                    bit_drive <= 1'b0;
                    evb_tgl <= ~evb_tgl;
                  end else begin
                    bit_drive <= ~shreg[6];
                    shreg <= {shreg[6:0], 1'b0};
                  end
                end
                ims_pkg::CMD_RX: begin
                  shreg <= {shreg[6:0], sda_s};
                  if (bitcnt == ims_pkg::BIT_EIGHTH) begin
                    res_rx <= {shreg[6:0], sda_s};
                    done_tgl <= ~done_tgl;
                    state <= ims_pkg::S_IDLE;
                  end
                end
                default: begin
                  done_tgl <= ~done_tgl;
                  state <= ims_pkg::S_IDLE;
                end
              endcase
            end
          end
          ims_pkg::S_STOP1: begin
            if (tick) begin
              scl_low <= 1'b0;
              state <= ims_pkg::S_STOP2;
            end
          end
          ims_pkg::S_STOP2: begin
            if (tick) begin
              sda_low <= 1'b0;
              state <= ims_pkg::S_STOP3;
            end
          end
          ims_pkg::S_STOP3: begin
            if (sda_s && scl_s && !stop_armed) begin
              evp_tgl <= ~evp_tgl;
              stop_armed <= 1'b1;
            end
            if (tick) begin
              stop_armed <= 1'b0;
              done_tgl <= ~done_tgl;
              state <= ims_pkg::S_IDLE;
            end
          end
          default: begin
            state <= ims_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // open-drain pins: only ever drive low, enable is active low
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_n <= ~scl_low;
      sda_oe_n <= ~sda_low;
    end
  end

endmodule : ims_master

// File: verification/ims_assertions.sv
// checker of the sequencer command bits and flags
`timescale 1ns/1ps
module ims_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic receive_set,
  input wire logic restart_set,
  input wire logic buf_wr,
  input wire logic start_request_bit,
  input wire logic restart_request_bit,
  input wire logic receive_request_bit,
  input wire logic ack_sequence_request,
  input wire logic stop_request_bit,
  input wire logic buffer_full_flag,
  input wire logic write_collision_flag,
  input wire logic port_irq_flag,
  input wire logic collision_irq_flag,
  input wire logic start_seen,
  input wire logic stop_seen
);
  default clocking dck @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_START_END: assert property ($fell(start_request_bit) |->
    start_seen && port_irq_flag || collision_irq_flag) else $error("start");
  AST_RS_END: assert property ($fell(restart_request_bit) |->
    start_seen && port_irq_flag || collision_irq_flag) else $error("rs");
  AST_RX_END: assert property ($fell(receive_request_bit) |->
    buffer_full_flag && port_irq_flag) else $error("rx end");
  AST_ACK_END: assert property ($fell(ack_sequence_request) |->
    port_irq_flag) else $error("ack end");
  AST_STOP_END: assert property ($fell(stop_request_bit) |->
    stop_seen && port_irq_flag) else $error("stop end");
  AST_RX_IGN: assert property (receive_set && restart_request_bit
    |=> !receive_request_bit) else $error("rx taken");
  AST_RS_IGN: assert property (restart_set && receive_request_bit
    |=> !restart_request_bit) else $error("rs taken");
  AST_WRITE_COLLISION_FLAG: assert property (buf_wr && start_request_bit |=>
    write_collision_flag && buffer_full_flag == $past(buffer_full_flag))
    else $error("write_collision_flag");
endmodule : ims_assertions

bind ims_master ims_assertions u_chk (.clk, .rst_n, .receive_set,
  .restart_set, .buf_wr, .start_request_bit, .restart_request_bit,
  .receive_request_bit, .ack_sequence_request, .stop_request_bit,
  .buffer_full_flag, .write_collision_flag, .port_irq_flag,
  .collision_irq_flag, .start_seen, .stop_seen);

// File: verification/ims_slave.sv
// slave partner: acks writes, serves reads msb first
`timescale 1ns/1ps
module ims_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic [7:0] rdata,
  output logic sda_n
);
  int n; // clock rises in this byte
  logic rd, adr, ak;
  logic [7:0] sh; // byte seen on the wire
  initial begin
    n = 0;
    rd = 0;
    adr = 0;
    ak = 1;
    sh = 8'h00;
    sda_n = 1;
  end
  // start or repeated start opens a new address byte
  always @(negedge sda) begin
    if (scl) begin
      n = 0;
      adr = 1;
      rd = 0;
    end
  end
  // data is taken while the clock is high
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    if (n == 8) ak = sda;
    n++;
  end
  // change only in the low phase; a master nack ends the read
  always @(negedge scl) begin
    if (n == 9) begin
      n = 0;
      rd = adr ? sh[0] : rd & !ak;
      adr = 0;
    end
    if (n == 8 && !rd) sda_n = nack;
    else if (n < 8 && rd) sda_n = rdata[7-n];
    else sda_n = 1;
  end
endmodule : ims_slave

// File: verification/tb.sv
// bench: sequencer against the slave and a reference
`timescale 1ns/1ps
module tb;
  logic clk, link_clk, rst_n, buf_rd, ack_v, nack, hold_n, pull_n, stretch;
  logic [5:0] req; // start restart receive ack stop write
  logic [2:0] clr;
  logic [7:0] wdata, rdata, baud;
  logic [31:0] seed;
  logic [7:0] q[$]; // expected bytes
  int errors, n_compared, cyc, t;
  wire start_request_bit, restart_request_bit, receive_request_bit;
  wire buffer_full_flag, write_collision_flag, port_irq_flag;
  wire collision_irq_flag, slave_ack_result, start_seen, stop_seen;
  wire scl_oe_n, sda_oe_n, sda_n;
  wire ack_sequence_request, stop_request_bit, scl_out, sda_out;
  wire [7:0] transfer_buffer;
  wire scl = scl_oe_n & hold_n;
  wire sda = sda_oe_n & sda_n & pull_n;
  wire [7:0] st = {start_request_bit, restart_request_bit,
    receive_request_bit, buffer_full_flag, write_collision_flag,
    port_irq_flag, collision_irq_flag, slave_ack_result};
  wire [7:0] ln = {ack_sequence_request, stop_request_bit, scl_out,
    sda_out, start_seen, stop_seen, scl, sda};
  ims_master dut (.clk, .rst_n, .link_clk, .start_set(req[0]),
    .restart_set(req[1]), .receive_set(req[2]), .ack_set(req[3]),
    .stop_set(req[4]), .buf_wr(req[5]), .ack_value_to_send(ack_v),
    .baud_reload_value(baud), .buf_wdata(wdata), .buf_rd,
    .port_irq_clr(clr[0]), .collision_irq_clr(clr[1]),
    .write_collision_clr(clr[2]), .scl_in(scl), .sda_in(sda),
    .start_request_bit, .restart_request_bit, .receive_request_bit,
    .ack_sequence_request, .stop_request_bit, .buffer_full_flag,
    .write_collision_flag, .port_irq_flag, .collision_irq_flag,
    .slave_ack_result, .start_seen, .stop_seen, .transfer_buffer,
    .scl_out, .scl_oe_n, .sda_out, .sda_oe_n);
  ims_slave u_slave (.scl, .sda, .nack, .rdata, .sda_n);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 0;
    #7.3;
    forever #24 link_clk = ~link_clk;
  end
  // slow slave stretches each low phase
  always @(negedge scl) begin
    if (stretch) begin
      hold_n = 0;
      #300 hold_n = 1;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      conclude();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // clear flags, issue m, intrude x while busy, wait for the end
  task automatic go(input logic [5:0] m, input logic [5:0] x);
    @(posedge clk) clr <= 3'h7;
    @(posedge clk) clr <= 3'h0;
    void'(rnd());
    baud <= 8'h03 + {6'h00, seed[1:0]};
    req <= m;
    @(posedge clk) req <= 6'h00;
    repeat (20) @(posedge clk);
    req <= x;
    wdata <= ~wdata;
    @(posedge clk) req <= 6'h00;
    t = 0;
    while ((port_irq_flag | collision_irq_flag) !== 1'b1 && t < 4000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 4000) errors++;
    // pins move one link cycle after the done toggle, so wait past it
    repeat (20) @(negedge clk);
  endtask : go
  initial begin
    seed = 32'h2c82_07da;
    rst_n = 0;
    req = 6'h00;
    clr = 3'h0;
    buf_rd = 0;
    ack_v = 0;
    nack = 0;
    hold_n = 1;
    pull_n = 1;
    stretch = 0;
    wdata = 8'h00;
    rdata = 8'h00;
    baud = 8'h03;
    repeat (20) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    pull_n <= 0;
    go(6'h01, 6'h00);
    chk(st, 8'h02);
    @(posedge clk) pull_n <= 1;
    go(6'h01, 6'h20);
    chk(st, 8'h0c);
    chk(ln, 8'h0a);
    chk(transfer_buffer, 8'h00);
    @(posedge clk) wdata <= 8'ha4;
    q.push_back(8'ha4);
    go(6'h20, 6'h20);
    chk(st, 8'h0c);
    chk(transfer_buffer, 8'ha4);
    chk(u_slave.sh, q.pop_front());
    chk(ln, 8'h09);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) wdata <= 8'(rnd());
      nack <= 1'(i);
      q.push_back(8'(seed));
      go(6'h20, 6'h00);
      chk(st, 8'h04 + 8'(i));
      chk(u_slave.sh, q.pop_front());
    end
    go(6'h02, 6'h04);
    // the nack of the last written byte still stands
    chk(st, 8'h05);
    chk(ln, 8'h08);
    @(posedge clk) wdata <= 8'ha5;
    nack <= 0;
    rdata <= 8'(rnd());
    stretch <= 1;
    go(6'h20, 6'h00);
    chk(st, 8'h04);
    for (int i = 0; i < 2; i++) begin
      q.push_back(rdata);
      go(6'h04, 6'h02);
      chk(st, 8'h14);
      chk(transfer_buffer, q.pop_front());
      @(posedge clk) buf_rd <= 1;
      rdata <= 8'(rnd());
      ack_v <= 1'(i);
      @(posedge clk) buf_rd <= 0;
      @(negedge clk) chk(st, 8'h04);
      go(6'h08, 6'h00);
      chk(st, 8'h04);
    end
    go(6'h10, 6'h00);
    chk(st, 8'h04);
    chk(ln, 8'h07);
    conclude();
  end
endmodule : tb
